// >>> core/dbe_pkg.sv
// Constants and types for the data, bit and flag instruction executor.
// Assumes one core clock and a decoder that hands over one operation.
package dbe_pkg;
	localparam int NREG = 32;
	localparam int REG_Z_LO = 30;
	localparam int REG_Z_HI = 31;
	localparam int REG_R0 = 0;
	// Status flags register bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;
	localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BIT_ONE = 8'h01;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [5:0] IO_ADDR_RST = 6'h00;
	typedef enum logic [4:0] {
		OP_NOP, OP_MEM_RD, OP_MEM_WR, OP_COPY, OP_IMM, OP_IO_IN,
		OP_IO_OUT, OP_PM_RD, OP_IO_SET, OP_IO_CLR, OP_SHL, OP_SHR,
		OP_ROL, OP_ROR, OP_ASR, OP_SWAP, OP_FLAG_SET, OP_FLAG_CLR,
		OP_BST, OP_BLD, OP_SLEEP, OP_WDR
	} dbe_op_e;
	typedef enum logic [2:0] {
		ST_IDLE, ST_MEM_RD, ST_WAIT, ST_PM_ADDR, ST_PM_DATA
	} dbe_state_e;
endpackage

// >>> core/dbe_exec.sv
// Executor for data transfer, bit, shift, flag, sleep and watchdog ops.
// Assumes a decoder presenting one operation with op_valid while ready,
// an I/O space answering io_rdata for io_port in the same cycle, and data
// and program memories that answer in the same cycle as their read strobe.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Pointer read loads Rd from data memory at Z, flags kept, two cycles.
// - Pointer write stores Rr to data memory at Z, flags kept, two cycles.
// - Program memory read puts byte at Z into R0, flags kept, three cycles.
// - I/O bit set forces chosen I/O bit to one, flags kept, two cycles.
// - I/O bit clear forces chosen I/O bit to zero, flags kept, two cycles.
// - Left shift moves bits up, zero into bit 0, sets Z C N V, one cycle.
// - Right shift moves bits down, zero into bit 7, sets Z C N V, one cycle.
// - Left rotate feeds carry to bit 0, bit 7 to carry, one cycle.
// - Right rotate feeds carry to bit 7, bit 0 to carry, one cycle.
// - Signed right shift keeps bit 7, sets Z C N V, one cycle.
// - Nibble swap exchanges register halves, flags kept, one cycle.
// - Bit to transfer flag copies register bit into T only, one cycle.
// - Transfer flag to bit writes T into register bit, one cycle.
// - Flag set or clear changes only the chosen status bit, one cycle.
// - Sleep issues in one cycle, flags kept, requests low-power sleep.
// - Watchdog restart takes one cycle, flags kept, pulses restart.
module dbe_exec
	import dbe_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire dbe_op_e op,
	input wire logic [4:0] rd_sel,
	input wire logic [4:0] rr_sel,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire logic [5:0] io_port,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] mem_rdata,
	input wire logic [15:0] pm_rdata,
	input wire logic [4:0] dbg_sel,
	output logic ready,
	output logic done,
	output logic [7:0] status_flags_register,
	output logic [7:0] dbg_data,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_re,
	output logic mem_we,
	output logic [14:0] pm_addr,
	output logic pm_re,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic sleep_req,
	output logic wdt_restart
);
	logic [7:0] regs [NREG];
	logic [7:0] next_regs [NREG];
	dbe_state_e state, next_state;
	logic [7:0] next_status_flags_register, next_dbg, next_mem_wdata, next_io_wdata;
	logic [7:0] pm_hold, next_pm_hold;
	logic [15:0] next_mem_addr;
	logic [14:0] next_pm_addr;
	logic [5:0] next_io_addr;
	logic [4:0] dest, next_dest;
	logic pm_hi, next_pm_hi;
	logic next_ready, next_done, next_mem_re, next_mem_we;
	logic next_pm_re, next_io_we, next_sleep, next_wdt;
	logic take;
	logic [7:0] rd_val, rr_val, sh_res, bit_mask;
	logic [15:0] zptr;
	logic sh_c;

	// Operand views; Z is the R31:R30 pair
	assign rd_val = regs[rd_sel];
	assign rr_val = regs[rr_sel];
	assign zptr = {regs[REG_Z_HI], regs[REG_Z_LO]};
	assign bit_mask = BIT_ONE << bit_sel;
	assign take = op_valid && (state == ST_IDLE);

	// Shift and rotate result with outgoing carry
	always_comb
	begin
		sh_res = rd_val;
		sh_c = status_flags_register[FLG_C];
		case (op)
			OP_SHL:
			begin
				sh_res = {rd_val[6:0], 1'b0};
				sh_c = rd_val[7];
			end
			OP_SHR:
			begin
				sh_res = {1'b0, rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_ROL:
			begin
				sh_res = {rd_val[6:0], status_flags_register[FLG_C]};
				sh_c = rd_val[7];
			end
			OP_ROR:
			begin
				sh_res = {status_flags_register[FLG_C], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			OP_ASR:
			begin
				sh_res = {rd_val[7], rd_val[7:1]};
				sh_c = rd_val[0];
			end
			default:
			begin
				sh_res = rd_val;
				sh_c = status_flags_register[FLG_C];
			end
		endcase
	end

	// Sequencer and datapath next values; one op at a time, no overlap
	always_comb
	begin
		next_regs = regs;
		next_status_flags_register = status_flags_register;
		next_state = state;
		next_done = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_re = 1'b0;
		next_mem_we = 1'b0;
		next_pm_addr = pm_addr;
		next_pm_re = 1'b0;
		next_pm_hold = pm_hold;
		next_pm_hi = pm_hi;
		next_io_addr = io_addr;
		next_io_wdata = io_wdata;
		next_io_we = 1'b0;
		next_sleep = 1'b0;
		next_wdt = 1'b0;
		next_dest = dest;
		case (state)
			ST_IDLE:
			begin
				if (take)
				begin
					next_done = 1'b1;
					case (op)
						OP_MEM_RD:
						begin
							next_mem_addr = zptr;
							next_mem_re = 1'b1;
							next_dest = rd_sel;
							next_done = 1'b0;
							next_state = ST_MEM_RD;
						end
						OP_MEM_WR:
						begin
							next_mem_addr = zptr;
							next_mem_wdata = rr_val;
							next_mem_we = 1'b1;
							next_done = 1'b0;
							next_state = ST_WAIT;
						end
						OP_PM_RD:
						begin
							next_pm_addr = zptr[15:1];
							next_pm_hi = zptr[0];
							next_pm_re = 1'b1;
							next_done = 1'b0;
							next_state = ST_PM_ADDR;
						end
						OP_IO_SET, OP_IO_CLR:
						begin
							// Read-modify-write of one I/O register
							next_io_addr = io_port;
							next_io_wdata = (op == OP_IO_SET) ?
								(io_rdata | bit_mask) :
								(io_rdata & ~bit_mask);
							next_io_we = 1'b1;
							next_done = 1'b0;
							next_state = ST_WAIT;
						end
						OP_COPY: next_regs[rd_sel] = rr_val;
						OP_IMM: next_regs[rd_sel] = imm;
						OP_IO_IN: next_regs[rd_sel] = io_rdata;
						OP_IO_OUT:
						begin
							next_io_addr = io_port;
							next_io_wdata = rr_val;
							next_io_we = 1'b1;
						end
						OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR:
						begin
							// S and H are not touched by these shifts
							next_regs[rd_sel] = sh_res;
							next_status_flags_register[FLG_C] = sh_c;
							next_status_flags_register[FLG_Z] = (sh_res == BYTE_ZERO);
							next_status_flags_register[FLG_N] = sh_res[7];
							next_status_flags_register[FLG_V] = sh_res[7] ^ sh_c;
						end
						OP_SWAP:
							next_regs[rd_sel] =
								{rd_val[3:0], rd_val[7:4]};
						OP_FLAG_SET: next_status_flags_register[bit_sel] = 1'b1;
						OP_FLAG_CLR: next_status_flags_register[bit_sel] = 1'b0;
						OP_BST: next_status_flags_register[FLG_T] = rd_val[bit_sel];
						OP_BLD:
							next_regs[rd_sel][bit_sel] = status_flags_register[FLG_T];
						OP_SLEEP: next_sleep = 1'b1;
						OP_WDR: next_wdt = 1'b1;
						default: next_done = 1'b1;
					endcase
				end
			end
			ST_MEM_RD:
			begin
				next_regs[dest] = mem_rdata;
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			ST_WAIT:
			begin
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			ST_PM_ADDR:
			begin
				// Odd Z picks the high byte of the program word
				next_pm_hold = pm_hi ? pm_rdata[15:8] : pm_rdata[7:0];
				next_state = ST_PM_DATA;
			end
			ST_PM_DATA:
			begin
				next_regs[REG_R0] = pm_hold;
				next_done = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		next_ready = (next_state == ST_IDLE);
		next_dbg = next_regs[dbg_sel];
	end

	// State registers; the register file clears with the rest on reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			regs <= '{default: BYTE_ZERO};
			state <= ST_IDLE;
			status_flags_register <= STATUS_FLAGS_REGISTER_RST;
			ready <= 1'b1;
			done <= 1'b0;
			dbg_data <= BYTE_ZERO;
			mem_addr <= ADDR_RST;
			mem_wdata <= BYTE_ZERO;
			mem_re <= 1'b0;
			mem_we <= 1'b0;
			pm_addr <= ADDR_RST[14:0];
			pm_re <= 1'b0;
			pm_hold <= BYTE_ZERO;
			pm_hi <= 1'b0;
			io_addr <= IO_ADDR_RST;
			io_wdata <= BYTE_ZERO;
			io_we <= 1'b0;
			sleep_req <= 1'b0;
			wdt_restart <= 1'b0;
			dest <= 5'h00;
		end
		else
		begin
			regs <= next_regs;
			state <= next_state;
			status_flags_register <= next_status_flags_register;
			ready <= next_ready;
			done <= next_done;
			dbg_data <= next_dbg;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_re <= next_mem_re;
			mem_we <= next_mem_we;
			pm_addr <= next_pm_addr;
			pm_re <= next_pm_re;
			pm_hold <= next_pm_hold;
			pm_hi <= next_pm_hi;
			io_addr <= next_io_addr;
			io_wdata <= next_io_wdata;
			io_we <= next_io_we;
			sleep_req <= next_sleep;
			wdt_restart <= next_wdt;
			dest <= next_dest;
		end
	end

	// Checks on timing and flag effects
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_mem_rd;
		take && op == OP_MEM_RD |=> !ready && mem_re ##1 done && ready
			&& $stable(status_flags_register);
	endproperty
	a_mem_rd: assert property (p_mem_rd)
		else $error("pointer read timing or flags wrong");

	property p_mem_wr;
		take && op == OP_MEM_WR |=> mem_we && mem_addr == $past(zptr)
			&& mem_wdata == $past(rr_val) ##1 done && status_flags_register == $past(status_flags_register, 2);
	endproperty
	a_mem_wr: assert property (p_mem_wr)
		else $error("pointer write wrong");

	property p_pm_rd;
		take && op == OP_PM_RD |=> pm_re && !ready ##1 !ready
			##1 done && ready && $stable(status_flags_register);
	endproperty
	a_pm_rd: assert property (p_pm_rd)
		else $error("program memory read timing wrong");

	property p_io_set;
		take && op == OP_IO_SET |=> io_we && io_wdata[$past(bit_sel)]
			&& io_addr == $past(io_port) ##1 done;
	endproperty
	a_io_set: assert property (p_io_set)
		else $error("I/O bit set wrong");

	property p_io_clr;
		take && op == OP_IO_CLR |=> io_we && !io_wdata[$past(bit_sel)]
			##1 done && ready;
	endproperty
	a_io_clr: assert property (p_io_clr)
		else $error("I/O bit clear wrong");

	property p_shl;
		take && op == OP_SHL |=> done && status_flags_register[FLG_C] == $past(rd_val[7])
			&& regs[$past(rd_sel)][0] == 1'b0;
	endproperty
	a_shl: assert property (p_shl)
		else $error("left shift wrong");

	property p_ror;
		take && op == OP_ROR |=> regs[$past(rd_sel)][7] == $past(status_flags_register[FLG_C])
			&& status_flags_register[FLG_C] == $past(rd_val[0]);
	endproperty
	a_ror: assert property (p_ror)
		else $error("right rotate wrong");

	property p_asr;
		take && op == OP_ASR |=> regs[$past(rd_sel)][7] == $past(rd_val[7])
			&& status_flags_register[FLG_N] == $past(rd_val[7]);
	endproperty
	a_asr: assert property (p_asr)
		else $error("signed shift wrong");

	property p_bst;
		take && op == OP_BST |=> status_flags_register[FLG_T] == $past(rd_val[bit_sel])
			&& status_flags_register[5:0] == $past(status_flags_register[5:0]) && done;
	endproperty
	a_bst: assert property (p_bst)
		else $error("bit to transfer flag wrong");

	property p_flag;
		take && op == OP_FLAG_SET |=> status_flags_register[$past(bit_sel)] && done && ready;
	endproperty
	a_flag: assert property (p_flag)
		else $error("flag set wrong");

	// A second restart taken back to back may legally keep the pulse high
	property p_wdt;
		take && op == OP_WDR |=> wdt_restart && $stable(status_flags_register)
			##1 (!wdt_restart || $past(take && op == OP_WDR));
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog restart pulse wrong");
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the data, bit and flag instruction executor.
// Assumes dbe_exec and dbe_pkg; data memory, program memory and I/O
// space are modelled here as plain functions of the address.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import dbe_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic op_valid = 1'b0;
	dbe_op_e op = OP_NOP;
	logic [4:0] rd_sel = 5'h00;
	logic [4:0] rr_sel = 5'h00;
	logic [4:0] dbg_sel = 5'h00;
	logic [7:0] imm = 8'h00;
	logic [2:0] bit_sel = 3'h0;
	logic [5:0] io_port = 6'h00;
	logic [7:0] io_rdata, mem_rdata, status_flags_register, dbg_data, mem_wdata, io_wdata;
	logic [15:0] pm_rdata, mem_addr;
	logic [14:0] pm_addr;
	logic [5:0] io_addr;
	logic ready, done, mem_re, mem_we, pm_re, io_we, sleep_req, wdt_restart;
	logic [7:0] m_reg [32];
	logic [7:0] m_status_flags_register = 8'h00;
	logic [7:0] rs = 8'h4E;
	int err_count = 0;
	int check_count = 0;

	// Memory contents are address hashes, so a wrong address shows up
	function automatic logic [7:0] mfun(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	function automatic logic [15:0] pfun(input logic [14:0] a);
		return {a[7:0] ^ 8'hA5, a[14:7]};
	endfunction
	function automatic logic [7:0] iofun(input logic [5:0] p);
		return {p, 2'b10} ^ 8'h96;
	endfunction
	function automatic logic [7:0] rnd();
		rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
		return rs;
	endfunction

	// Idle read data is inverted so a late sample cannot match
	assign mem_rdata = mem_re ? mfun(mem_addr) : ~mfun(mem_addr);
	assign pm_rdata = pm_re ? pfun(pm_addr) : ~pfun(pm_addr);
	assign io_rdata = iofun(io_port);

	dbe_exec DUT (
		.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
		.rd_sel(rd_sel), .rr_sel(rr_sel), .imm(imm), .bit_sel(bit_sel),
		.io_port(io_port), .io_rdata(io_rdata), .mem_rdata(mem_rdata),
		.pm_rdata(pm_rdata), .dbg_sel(dbg_sel), .ready(ready), .done(done),
		.status_flags_register(status_flags_register), .dbg_data(dbg_data), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_re(mem_re), .mem_we(mem_we),
		.pm_addr(pm_addr), .pm_re(pm_re), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_we(io_we), .sleep_req(sleep_req),
		.wdt_restart(wdt_restart)
	);

	// Clock at 10 MHz
	always #50 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One operation: predict, offer for one edge, then compare everything
	task automatic do_op(input dbe_op_e o, input logic [4:0] d, r,
		input logic [7:0] k, input logic [2:0] b, input logic [5:0] p);
		logic [7:0] v, res, s;
		logic [15:0] z, pw;
		logic [5:0] stb;
		int lat, n, ck;
		v = m_reg[d];
		z = {m_reg[REG_Z_HI], m_reg[REG_Z_LO]};
		pw = pfun(z[15:1]);
		res = v;
		s = m_status_flags_register;
		lat = 1;
		ck = d;
		stb = 6'h00;
		case (o)
			OP_MEM_RD: begin res = mfun(z); lat = 2; stb = 6'h20; end
			OP_MEM_WR: begin lat = 2; stb = 6'h10; end
			OP_COPY: res = m_reg[r];
			OP_IMM: res = k;
			OP_IO_IN: res = iofun(p);
			OP_IO_OUT: stb = 6'h04;
			OP_PM_RD: begin
				ck = REG_R0;
				res = z[0] ? pw[15:8] : pw[7:0];
				lat = 3;
				stb = 6'h08;
			end
			OP_IO_SET, OP_IO_CLR: begin lat = 2; stb = 6'h04; end
			OP_SHL: begin res = {v[6:0], 1'b0}; s[FLG_C] = v[7]; end
			OP_SHR: begin res = {1'b0, v[7:1]}; s[FLG_C] = v[0]; end
			OP_ROL: begin res = {v[6:0], m_status_flags_register[FLG_C]}; s[FLG_C] = v[7]; end
			OP_ROR: begin res = {m_status_flags_register[FLG_C], v[7:1]}; s[FLG_C] = v[0]; end
			OP_ASR: begin res = {v[7], v[7:1]}; s[FLG_C] = v[0]; end
			OP_SWAP: res = {v[3:0], v[7:4]};
			OP_FLAG_SET: s[b] = 1'b1;
			OP_FLAG_CLR: s[b] = 1'b0;
			OP_BST: s[FLG_T] = v[b];
			OP_BLD: res[b] = m_status_flags_register[FLG_T];
			OP_SLEEP: stb = 6'h02;
			OP_WDR: stb = 6'h01;
			default: ;
		endcase
		if (o inside {OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR})
		begin
			s[FLG_Z] = (res == 8'h00);
			s[FLG_N] = res[7];
			s[FLG_V] = res[7] ^ s[FLG_C];
		end
		@(negedge clk);
		op_valid = 1'b1;
		op = o;
		rd_sel = d;
		rr_sel = r;
		imm = k;
		bit_sel = b;
		io_port = p;
		@(negedge clk);
		op_valid = 1'b0;
		check({mem_re, mem_we, pm_re, io_we, sleep_req, wdt_restart}, stb);
		check(ready, lat == 1);
		if (o == OP_MEM_RD || o == OP_MEM_WR)
			check(mem_addr, z);
		if (o == OP_MEM_WR)
			check(mem_wdata, m_reg[r]);
		if (o == OP_PM_RD)
			check(pm_addr, z[15:1]);
		if (stb == 6'h04)
			check({io_addr, io_wdata}, {p, o == OP_IO_OUT ? m_reg[r] :
				o == OP_IO_SET ? iofun(p) | (8'h01 << b) :
				iofun(p) & ~(8'h01 << b)});
		n = 1;
		while (done !== 1'b1 && n < 6)
		begin
			@(negedge clk);
			n++;
		end
		check(n, lat);
		m_reg[ck] = res;
		m_status_flags_register = s;
		dbg_sel = 5'(ck);
		check(status_flags_register, s);
		@(negedge clk);
		check(dbg_data, res);
	endtask

	// Main sequence: reset, fill registers, corners, then random ops
	initial
	begin
		logic [7:0] a, c, e, g;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		check({ready, done, status_flags_register}, 10'h200);
		for (int i = 0; i < 32; i++)
			do_op(OP_IMM, 5'(i), 5'h00, rnd(), 3'h0, 6'h00);
		// Shift out the top bit to reach zero with carry set
		do_op(OP_IMM, 5'h05, 5'h00, 8'h80, 3'h0, 6'h00);
		do_op(OP_SHL, 5'h05, 5'h00, 8'h00, 3'h0, 6'h00);
		do_op(OP_ROR, 5'h05, 5'h00, 8'h00, 3'h0, 6'h00);
		do_op(OP_ASR, 5'h05, 5'h00, 8'h00, 3'h0, 6'h00);
		for (int i = 0; i < 440; i++)
		begin
			a = rnd();
			c = rnd();
			e = rnd();
			g = rnd();
			do_op(dbe_op_e'(5'(i % 22)), a[4:0], c[4:0], e, g[2:0], c[7:2]);
		end
		finish_test();
	end

	// A hang is cut short well past the expected run length
	initial
	begin
		#1000000;
		err_count++;
		$display("unexpected at %0t: seen %h expected %h", $time, 0, 1);
		finish_test();
	end
endmodule

`default_nettype wire
